// >>> include/zpc_params.svh
// constants for the zero point and configuration command handler
// Function
// - a command ends with CR then LF; the pair triggers execution
// - force-zero 'u' loads the value as zero point and echoes it
// - concentrations from u, X and G are scaled by the multiplier
// - known-gas 'X' recomputes zero from the concentration and echoes the result
// - P 8 / P 9 load high / low byte of the auto-zero background level
// - P 10 / P 11 load high / low byte of the fresh-air level
// - '@' stores initial and regular interval in tenths of a day and echoes them
// - auto-zero is off after reset until valid intervals arrive
// - '@' with one zero argument disables auto-zero
// - '@' without arguments reports the configuration unchanged
// - 'S' stores the compensation value, default 8192, range 0..65536; range not checked, any 17-bit argument is stored
// - 's' returns compensation as five zero-padded digits after letter and space
// - 'S' replies with letter and the accepted value in five digits
// - fresh-air 'G' uses the P 10/11 level when computing zero
`ifndef ZPC_PARAMS_SVH
`define ZPC_PARAMS_SVH
`define ZPC_CR 8'h0D
`define ZPC_LF 8'h0A
`define ZPC_SP 8'h20
`define ZPC_DOT 8'h2E
`define ZPC_ZERO_CH 8'h30
`define ZPC_CMD_FORCE 8'h75
`define ZPC_CMD_KNOWN 8'h58
`define ZPC_CMD_FRESH 8'h47
`define ZPC_CMD_PSET 8'h50
`define ZPC_CMD_IVAL 8'h40
`define ZPC_CMD_CSET 8'h53
`define ZPC_CMD_CGET 8'h73
`define ZPC_IDX_BG_HI 17'h00008
`define ZPC_IDX_BG_LO 17'h00009
`define ZPC_IDX_FR_HI 17'h0000A
`define ZPC_IDX_FR_LO 17'h0000B
`define ZPC_COMP_RST 17'h02000
`define ZPC_LEVEL_RST 16'h0190
`define ZPC_ZERO_RST 17'h07FFF
`define ZPC_MULT_RST 8'h01
`define ZPC_REG_MULT 8'h00
`define ZPC_REG_ZERO 8'h04
`define ZPC_REG_LEVEL 8'h08
`define ZPC_REG_AZ 8'h0C
`define ZPC_REG_COMP 8'h10
`define ZPC_REG_STAT 8'h14
`endif

// >>> include/zpc_pkg.sv
// types for the zero point and configuration command handler
package zpc_pkg;
    typedef enum logic [1:0] {PS_IDLE, PS_ARGS, PS_BAD, PS_WLF} zpc_pstate_type;
    typedef struct packed {
        logic en;
        logic [9:0] init_tenths;
        logic [9:0] regular_tenths;
    } zpc_az_cfg_type;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } zpc_byte_type;
endpackage : zpc_pkg

// >>> src/zpc_cmd_handler.sv
// ascii command handler for zero point, levels, auto-zero and compensation
`timescale 1ns/1ps
`include "zpc_params.svh"
module zpc_cmd_handler
    import zpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire zpc_byte_type rx,
    output logic rx_ready,
    output zpc_byte_type tx,
    input wire logic tx_ready,
    input wire logic [16:0] meas_signal,
    output logic [16:0] zero_point,
    output zpc_az_cfg_type az_cfg,
    output logic [16:0] comp_value
);
    zpc_pstate_type pst_q;
    logic [7:0] cmd_q;
    logic [16:0] acc_q;
    logic have_q;
    logic [1:0] nargs_q;
    logic [16:0] arg_q [2];
    logic [7:0] mult_q;
    logic [7:0] bg_hi_q, bg_lo_q, fr_hi_q, fr_lo_q;
    logic [16:0] zero_d, comp_d;
    zpc_az_cfg_type az_d;
    logic [7:0] bg_hi_d, bg_lo_d, fr_hi_d, fr_lo_d;
    logic [7:0] rb_d [16];
    logic [7:0] rb_q [16];
    logic [4:0] len_d, len_q, idx_q;
    logic reply_d, busy_q;
    logic take, exec;

    function automatic logic [16:0] scale(input logic [16:0] v, input logic [7:0] m);
        scale = 17'(v * m);
    endfunction : scale

    function automatic logic [7:0] dig(input logic [16:0] v, input logic [2:0] k);
        logic [16:0] p, q;
        unique case (k)
            3'd0: p = 17'd1;
            3'd1: p = 17'd10;
            3'd2: p = 17'd100;
            3'd3: p = 17'd1000;
            default: p = 17'd10000;
        endcase
        q = v / p;
        dig = `ZPC_ZERO_CH + 8'(q % 17'd10);
    endfunction : dig

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= 8'h30) && (c <= 8'h39);
    endfunction : is_digit

    assign take = rx.valid && rx_ready;
    assign exec = take && rx.data == `ZPC_LF && pst_q == PS_WLF;

    // line parser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_q <= PS_IDLE;
            cmd_q <= 8'h00;
            acc_q <= 17'h00000;
            have_q <= 1'b0;
            nargs_q <= 2'd0;
            arg_q[0] <= 17'h00000;
            arg_q[1] <= 17'h00000;
        end else if (take) begin
            if (rx.data == `ZPC_CR) begin
                pst_q <= (pst_q == PS_ARGS) ? PS_WLF : PS_BAD;
                if (pst_q == PS_ARGS && have_q) begin
                    if (nargs_q < 2'd2) begin
                        arg_q[nargs_q[0]] <= acc_q;
                    end
                    nargs_q <= (nargs_q == 2'd3) ? 2'd3 : nargs_q + 2'd1;
                end
            end else if (rx.data == `ZPC_LF) begin
                pst_q <= PS_IDLE;
            end else begin
                unique case (pst_q)
                    PS_IDLE: begin
                        if (rx.data != `ZPC_SP) begin
                            cmd_q <= rx.data;
                            pst_q <= PS_ARGS;
                            nargs_q <= 2'd0;
                            acc_q <= 17'h00000;
                            have_q <= 1'b0;
                        end
                    end
                    PS_ARGS: begin
                        if (is_digit(rx.data)) begin
                            acc_q <= 17'(acc_q * 17'd10) + 17'(rx.data - `ZPC_ZERO_CH);
                            have_q <= 1'b1;
                        end else if (rx.data == `ZPC_SP) begin
                            if (have_q) begin
                                if (nargs_q < 2'd2) begin
                                    arg_q[nargs_q[0]] <= acc_q;
                                end
                                nargs_q <= (nargs_q == 2'd3) ? 2'd3 : nargs_q + 2'd1;
                            end
                            acc_q <= 17'h00000;
                            have_q <= 1'b0;
                        end else if (rx.data != `ZPC_DOT) begin
                            pst_q <= PS_BAD;
                        end
                    end
                    PS_WLF: pst_q <= PS_BAD;
                    PS_BAD: pst_q <= PS_BAD;
                endcase
            end
        end
    end

    // command decode and reply text
    always_comb begin
        logic [4:0] n;
        logic [16:0] v [2];
        logic [1:0] nf;
        logic tenths;
        n = 5'd2;
        v[0] = 17'h00000;
        v[1] = 17'h00000;
        nf = 2'd0;
        tenths = 1'b0;
        reply_d = 1'b1;
        zero_d = zero_point;
        comp_d = comp_value;
        az_d = az_cfg;
        bg_hi_d = bg_hi_q;
        bg_lo_d = bg_lo_q;
        fr_hi_d = fr_hi_q;
        fr_lo_d = fr_lo_q;
        rb_d = '{default: `ZPC_SP};
        unique case (cmd_q)
            `ZPC_CMD_FORCE: begin
                zero_d = scale(arg_q[0], mult_q);
                reply_d = nargs_q != 2'd0;
            end
            `ZPC_CMD_KNOWN: begin
                zero_d = meas_signal - scale(arg_q[0], mult_q);
                reply_d = nargs_q != 2'd0;
            end
            `ZPC_CMD_FRESH: zero_d = meas_signal - scale({1'b0, fr_hi_q, fr_lo_q}, mult_q);
            `ZPC_CMD_PSET: begin
                nf = 2'd2;
                v[0] = arg_q[0];
                v[1] = {9'h000, arg_q[1][7:0]};
                reply_d = nargs_q == 2'd2;
                unique case (arg_q[0])
                    `ZPC_IDX_BG_HI: bg_hi_d = arg_q[1][7:0];
                    `ZPC_IDX_BG_LO: bg_lo_d = arg_q[1][7:0];
                    `ZPC_IDX_FR_HI: fr_hi_d = arg_q[1][7:0];
                    `ZPC_IDX_FR_LO: fr_lo_d = arg_q[1][7:0];
                    default: reply_d = 1'b0;
                endcase
            end
            `ZPC_CMD_IVAL: begin
                if (nargs_q == 2'd2) begin
                    az_d = '{1'b1, arg_q[0][9:0], arg_q[1][9:0]};
                end else if (nargs_q == 2'd1) begin
                    reply_d = arg_q[0] == 17'h00000;
                    if (reply_d) begin
                        az_d.en = 1'b0;
                    end
                end else if (nargs_q != 2'd0) begin
                    reply_d = 1'b0;
                end
                tenths = az_d.en;
                nf = az_d.en ? 2'd2 : 2'd1;
                v[0] = {7'h00, az_d.init_tenths};
                v[1] = {7'h00, az_d.regular_tenths};
            end
            `ZPC_CMD_CSET: begin
                comp_d = arg_q[0];
                reply_d = nargs_q != 2'd0;
            end
            `ZPC_CMD_CGET: ;
            default: reply_d = 1'b0;
        endcase
        if (cmd_q == `ZPC_CMD_FORCE || cmd_q == `ZPC_CMD_KNOWN || cmd_q == `ZPC_CMD_FRESH) begin
            nf = 2'd1;
            v[0] = zero_d;
        end
        if (cmd_q == `ZPC_CMD_CSET || cmd_q == `ZPC_CMD_CGET) begin
            nf = 2'd1;
            v[0] = comp_d;
        end
        rb_d[0] = cmd_q;
        for (int f = 0; f < 2; f++) begin
            if (2'(f) < nf) begin
                if (f != 0) begin
                    rb_d[n[3:0]] = `ZPC_SP;
                    n = n + 5'd1;
                end
                if (tenths) begin
                    if (v[f] >= 17'd100) begin
                        rb_d[n[3:0]] = dig(v[f], 3'd2);
                        n = n + 5'd1;
                    end
                    rb_d[n[3:0]] = dig(v[f], 3'd1);
                    rb_d[n[3:0] + 4'd1] = `ZPC_DOT;
                    rb_d[n[3:0] + 4'd2] = dig(v[f], 3'd0);
                    n = n + 5'd3;
                end else if (cmd_q == `ZPC_CMD_IVAL) begin
                    rb_d[n[3:0]] = `ZPC_ZERO_CH;
                    n = n + 5'd1;
                end else begin
                    for (int k = 4; k >= 0; k--) begin
                        rb_d[n[3:0]] = dig(v[f], 3'(k));
                        n = n + 5'd1;
                    end
                end
            end
        end
        rb_d[n[3:0]] = `ZPC_CR;
        rb_d[n[3:0] + 4'd1] = `ZPC_LF;
        len_d = n + 5'd2;
    end

    // settings updated by commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_point <= `ZPC_ZERO_RST;
            comp_value <= `ZPC_COMP_RST;
            az_cfg <= '0;
            {bg_hi_q, bg_lo_q} <= `ZPC_LEVEL_RST;
            {fr_hi_q, fr_lo_q} <= `ZPC_LEVEL_RST;
        end else if (exec && reply_d) begin
            zero_point <= zero_d;
            comp_value <= comp_d;
            az_cfg <= az_d;
            bg_hi_q <= bg_hi_d;
            bg_lo_q <= bg_lo_d;
            fr_hi_q <= fr_hi_d;
            fr_lo_q <= fr_lo_d;
        end
    end

    // reply transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            idx_q <= 5'd0;
            len_q <= 5'd0;
            tx <= '0;
            rx_ready <= 1'b0;
            rb_q <= '{default: 8'h00};
        end else begin
            rx_ready <= !busy_q && !(exec && reply_d) && !(tx.valid && tx_ready);
            if (exec && reply_d) begin
                busy_q <= 1'b1;
                rb_q <= rb_d;
                len_q <= len_d;
                idx_q <= 5'd1;
                tx <= '{1'b1, rb_d[0]};
            end else if (tx.valid && tx_ready) begin
                idx_q <= idx_q + 5'd1;
                tx.data <= rb_q[idx_q[3:0]];
                if (idx_q == len_q) begin
                    tx.valid <= 1'b0;
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // apb slave, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_q <= `ZPC_MULT_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    `ZPC_REG_MULT: begin
                        prdata <= {24'h000000, mult_q};
                        if (pwrite) begin
                            mult_q <= pwdata[7:0];
                        end
                    end
                    `ZPC_REG_ZERO: prdata <= {15'h0000, zero_point};
                    `ZPC_REG_LEVEL: prdata <= {fr_hi_q, fr_lo_q, bg_hi_q, bg_lo_q};
                    `ZPC_REG_AZ: prdata <= {11'h000, az_cfg};
                    `ZPC_REG_COMP: prdata <= {15'h0000, comp_value};
                    `ZPC_REG_STAT: prdata <= {29'h00000000, busy_q, pst_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_exec(logic [7:0] c);
        exec && cmd_q == c && nargs_q != 2'd0;
    endsequence

    chk_exec_on_lf: assert property (exec |-> $past(rx.data) == `ZPC_CR || $past(!take))
        else $error("execution without a CR LF pair");
    chk_force_zero: assert property (s_exec(`ZPC_CMD_FORCE) |=>
        zero_point == 17'($past(arg_q[0]) * $past(mult_q)))
        else $error("force zero not loaded scaled");
    chk_known_zero: assert property (s_exec(`ZPC_CMD_KNOWN) |=>
        zero_point == $past(meas_signal) - 17'($past(arg_q[0]) * $past(mult_q)))
        else $error("known gas zero wrong");
    chk_bg_high: assert property (exec && cmd_q == `ZPC_CMD_PSET && nargs_q == 2'd2
        && arg_q[0] == `ZPC_IDX_BG_HI |=> bg_hi_q == $past(arg_q[1][7:0]))
        else $error("background high byte not stored");
    chk_fresh_low: assert property (exec && cmd_q == `ZPC_CMD_PSET && nargs_q == 2'd2
        && arg_q[0] == `ZPC_IDX_FR_LO |=> fr_lo_q == $past(arg_q[1][7:0]))
        else $error("fresh air low byte not stored");
    chk_az_disable: assert property (exec && cmd_q == `ZPC_CMD_IVAL && nargs_q == 2'd1
        && arg_q[0] == 17'h00000 |=> !az_cfg.en)
        else $error("auto zero not disabled");
    chk_az_query: assert property (exec && cmd_q == `ZPC_CMD_IVAL && nargs_q == 2'd0
        |=> $stable(az_cfg) ##1 tx.valid)
        else $error("auto zero query changed state");
    chk_comp_reply: assert property (s_exec(`ZPC_CMD_CSET) |=>
        comp_value == $past(arg_q[0]) && tx.valid && tx.data == `ZPC_CMD_CSET)
        else $error("compensation not stored or echoed");
    chk_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("reply byte dropped under back pressure");
endmodule : zpc_cmd_handler

// >>> verif/test_zpc_cmd_handler.sv
// self-checking bench for the command handler
`timescale 1ns/1ps
module test_zpc_cmd_handler
    import zpc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    zpc_byte_type rx;
    zpc_byte_type tx;
    logic rx_ready;
    logic tx_ready;
    logic slow = 1'b0;
    logic [16:0] meas_signal = 17'h0;
    logic [16:0] zero_point;
    logic [16:0] meas_v;
    zpc_az_cfg_type az_cfg;
    logic [16:0] comp_value;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] exp_q[$];
    logic [15:0] seed = 16'h0011;
    logic [31:0] rd;
    logic er;
    always #2.5 pclk = ~pclk;
    zpc_cmd_handler zpc_cmd_handler_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx), .rx_ready(rx_ready),
        .tx(tx), .tx_ready(tx_ready), .meas_signal(meas_signal), .zero_point(zero_point),
        .az_cfg(az_cfg), .comp_value(comp_value));
    zpc_host_model zpc_host_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
        .rx_ready(rx_ready), .rx(rx), .tx_ready(tx_ready));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic string d5(input int v);
        return $sformatf("%05d", v);
    endfunction : d5
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rd_chk
    // reply noted before the line goes out
    task automatic cmd(input string s, input string r);
        if (r.len() > 0) begin
            for (int i = 0; i < r.len(); i++) begin
                exp_q.push_back(r[i]);
            end
            exp_q.push_back(8'h0D);
            exp_q.push_back(8'h0A);
        end
        zpc_host_model_inst.send_line(s, 1'b1);
    endtask : cmd
    task automatic settle();
        while (exp_q.size() != 0) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask : settle
    task automatic lvl(input int i, input int c);
        int hi;
        int lo;
        hi = c / 256;
        lo = c - 256 * hi;
        cmd($sformatf("P %0d %0d", i, hi), {"P ", d5(i), " ", d5(hi)});
        cmd($sformatf("P %0d %0d", i + 1, lo), {"P ", d5(i + 1), " ", d5(lo)});
    endtask : lvl
    always @(posedge pclk) begin
        if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("ERROR tx expected none seen %0h", tx.data);
            end else begin
                chk("tx", {24'h0, exp_q.pop_front()}, {24'h0, tx.data});
            end
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("mult", 8'h00, 32'h1);
        rd_chk("zero", 8'h04, 32'h7FFF);
        rd_chk("az", 8'h0C, 32'h0);
        cmd("s", "s 08192");
        settle();
        apb(1'b1, 8'h10, 32'h5);
        rd_chk("comp", 8'h10, 32'd8192);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("unmapped", 32'h0, rd);
        slow <= 1'b1;
        cmd("  S  77", "S 00077");
        cmd("S 65536", "S 65536");
        cmd("s", "s 65536");
        cmd("Q 5", "");
        zpc_host_model_inst.send_line("S 9", 1'b0);
        cmd("u", "");
        settle();
        rd_chk("comp", 8'h10, 32'd65536);
        chk("comp_port", 32'd65536, {15'h0, comp_value});
        cmd("u 32767", "u 32767");
        // slow reply still going out: busy set, parser idle
        rd_chk("stat_busy", 8'h14, 32'h4);
        settle();
        chk("zero_u", 32'd32767, {15'h0, zero_point});
        seed = lfsr(seed);
        meas_v = 17'd50000 + {4'h0, seed[12:0]};
        meas_signal <= meas_v;
        apb(1'b1, 8'h00, 32'h3);
        cmd("X 1000", {"X ", d5(int'(meas_v - 17'd3000))});
        settle();
        chk("zero_x", {15'h0, meas_v - 17'd3000}, {15'h0, zero_point});
        slow <= 1'b0;
        lvl(8, 400);
        lvl(10, 2000);
        settle();
        rd_chk("level", 8'h08, 32'h07D00190);
        apb(1'b1, 8'h00, 32'h1);
        cmd("G", {"G ", d5(int'(meas_v - 17'd2000))});
        settle();
        chk("zero_g", {15'h0, meas_v - 17'd2000}, {15'h0, zero_point});
        cmd("@ 1.0 8.0", "@ 1.0 8.0");
        settle();
        chk("az_cfg", {11'h0, 1'b1, 10'd10, 10'd80}, {11'h0, az_cfg});
        cmd("@", "@ 1.0 8.0");
        cmd("@ 12.5 0.5", "@ 12.5 0.5");
        settle();
        rd_chk("az", 8'h0C, {11'h0, 1'b1, 10'd125, 10'd5});
        cmd("@ 0", "@ 0");
        settle();
        chk("az_en", 32'h0, {31'h0, az_cfg.en});
        rd_chk("stat_idle", 8'h14, 32'h0);
        print_verdict();
    end
endmodule : test_zpc_cmd_handler

// >>> verif/zpc_host_model.sv
// host controller model: sends command lines, takes reply bytes
`timescale 1ns/1ps
module zpc_host_model
    import zpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic rx_ready,
    output zpc_byte_type rx,
    output logic tx_ready
);
    logic [2:0] cnt_q;
    initial rx = '{valid: 1'b0, data: 8'hFF};
    // slow mode takes a reply byte only half the time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
            tx_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            tx_ready <= slow ? cnt_q[2] : 1'b1;
        end
    end
    // byte held until an edge samples rx_ready high
    task automatic put(input logic [7:0] c);
        rx <= '{valid: 1'b1, data: c};
        do @(posedge pclk); while (rx_ready !== 1'b1);
    endtask : put
    task automatic send_line(input string s, input bit crlf);
        @(posedge pclk);
        for (int i = 0; i < s.len(); i++) begin
            put(s[i]);
        end
        if (crlf) begin
            put(8'h0D);
        end
        put(8'h0A);
        // released line shows the inverse of the last byte
        rx <= '{valid: 1'b0, data: 8'hF5};
    endtask : send_line
endmodule : zpc_host_model
